// file: hdl/hssc_pkg.sv
package hssc_pkg;
  // Register addresses (7-bit register address of the configuration port)
  localparam logic [6:0] ADDR_TIMER_A    = 7'h0C; // Timer_a control
  localparam logic [6:0] ADDR_TIMER_B    = 7'h0D; // Timer_b control
  localparam logic [6:0] ADDR_SHUTDOWN   = 7'h10; // Supply shutdown control
  localparam logic [6:0] ADDR_SRC_SEL_A  = 7'h14; // Switch 1 and 2 sources
  localparam logic [6:0] ADDR_SRC_SEL_B  = 7'h15; // Switch 3 and 4 sources
  localparam logic [7:0] RESET_VALUE     = 8'h00; // All registers
  // Writable bit masks; reserved bits read zero
  localparam logic [7:0] TIMER_MASK      = 8'h77; // Bits 6:4 and 2:0
  localparam logic [7:0] SHUTDOWN_MASK   = 8'h70; // Bits 6:4
  localparam logic [7:0] SRC_MASK        = 8'h77; // Two 3-bit fields
  // Field positions
  localparam int ON_LSB  = 4; // On-time field low bit
  localparam int PER_LSB = 0; // Period field low bit
  localparam int OV_BIT  = 6; // Overvoltage shutdown disable
  localparam int UV_BIT  = 5; // Undervoltage shutdown disable
  localparam int REC_BIT = 4; // Supply fault recovery
  // On-time codes
  localparam logic [2:0] ON_STOP_LOW  = 3'h0; // Stopped, output low
  localparam logic [2:0] ON_STOP_HIGH = 3'h6; // Stopped, output high
  localparam logic [2:0] ON_RSVD      = 3'h7; // Reserved
  localparam logic [2:0] PER_RSVD     = 3'h7; // Reserved
  // Switch source codes
  localparam logic [2:0] SRC_OFF     = 3'h0; // Off
  localparam logic [2:0] SRC_ON      = 3'h1; // On
  localparam logic [2:0] SRC_TIMER_A = 3'h2; // Timer_a
  localparam logic [2:0] SRC_TIMER_B = 3'h3; // Timer_b
  localparam logic [2:0] SRC_PWM_A   = 3'h4; // Pwm_a
  localparam logic [2:0] SRC_PWM_B   = 3'h5; // Pwm_b
  // Timing: one tick of 0.1 ms drives both timers
  localparam int CLK_HZ     = 250_000_000; // core_clk rate
  localparam int TICK_US    = 100;         // Tick length in us
  localparam int TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US; // 25000
  // On-times in ticks: 0.1, 0.3, 1.0, 10, 20 ms
  localparam logic [15:0] ON_T1 = 16'h0001;
  localparam logic [15:0] ON_T2 = 16'h0003;
  localparam logic [15:0] ON_T3 = 16'h000A;
  localparam logic [15:0] ON_T4 = 16'h0064;
  localparam logic [15:0] ON_T5 = 16'h00C8;
  // Periods in ticks: 10, 20, 50, 100, 200 ms, 1 s, 2 s
  localparam logic [15:0] PER_T0 = 16'h0064;
  localparam logic [15:0] PER_T1 = 16'h00C8;
  localparam logic [15:0] PER_T2 = 16'h01F4;
  localparam logic [15:0] PER_T3 = 16'h03E8;
  localparam logic [15:0] PER_T4 = 16'h07D0;
  localparam logic [15:0] PER_T5 = 16'h2710;
  localparam logic [15:0] PER_T6 = 16'h4E20;
endpackage : hssc_pkg

// file: hdl/hssc_top.sv
// Notes on behaviour
// - On-time code 000 stops timer, output low
// - On-time code 110 stops timer, output high
// - Period codes select 10ms to 2s
// - Timer starts once nonzero on-time written
// - Restart with cyclic sensing clears timer fields
// - Reserved bits ignore writes, read zero
// - Overvoltage switches off unless disabled
// - Undervoltage switches off unless disabled
// - Recovery restores previous state after fault
// - Register A holds switch 1 and 2
// - Register B holds switch 3 and 4
// - Overcurrent or overtemperature clears switch field
// - Timer_a shares encodings, preceding address
// - Timer wake and cyclic sensing run together
module hssc_top #(
  parameter int TICK_CYCLES = hssc_pkg::TICK_CYC // Cycles per 0.1 ms
) (
  input  wire logic       core_clk,      // 250 MHz clock
  input  wire logic       rstn,          // Async reset, active low
  input  wire logic       restartMode,   // Restart mode clear, level
  input  wire logic       cyclicSense,   // Cyclic sensing in use
  input  wire logic       regWrite,      // Write strobe, one cycle
  input  wire logic [6:0] regAddr,       // Register address
  input  wire logic [7:0] regWdata,      // Write data
  output logic      [7:0] regRdata,      // Read data, registered
  input  wire logic       supplyOv,      // Switch supply overvoltage pin
  input  wire logic       supplyUv,      // Switch supply undervoltage pin
  input  wire logic [3:0] switchFault,   // Overcurrent/overtemp pins
  input  wire logic       pwmA,          // Pwm_a generator output
  input  wire logic       pwmB,          // Pwm_b generator output
  output logic      [3:0] switchOn,      // Switch drive, registered
  output logic            timerAOut,     // Timer_a output for wake logic
  output logic            timerBOut      // Timer_b output for wake logic
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // On-time code to ticks; zero for non-running codes
  function automatic logic [15:0] onTicks(input logic [2:0] code);
    case (code)
      3'h1:    onTicks = hssc_pkg::ON_T1;
      3'h2:    onTicks = hssc_pkg::ON_T2;
      3'h3:    onTicks = hssc_pkg::ON_T3;
      3'h4:    onTicks = hssc_pkg::ON_T4;
      3'h5:    onTicks = hssc_pkg::ON_T5;
      default: onTicks = 16'h0000;
    endcase
  endfunction : onTicks

  // Period code to ticks; reserved gives zero (timer idle)
  function automatic logic [15:0] perTicks(input logic [2:0] code);
    case (code)
      3'h0:    perTicks = hssc_pkg::PER_T0;
      3'h1:    perTicks = hssc_pkg::PER_T1;
      3'h2:    perTicks = hssc_pkg::PER_T2;
      3'h3:    perTicks = hssc_pkg::PER_T3;
      3'h4:    perTicks = hssc_pkg::PER_T4;
      3'h5:    perTicks = hssc_pkg::PER_T5;
      3'h6:    perTicks = hssc_pkg::PER_T6;
      default: perTicks = 16'h0000;
    endcase
  endfunction : perTicks

  // Source code to drive level; reserved codes keep switch off
  function automatic logic srcLevel(input logic [2:0] code,
                                    input logic ta, input logic tb,
                                    input logic pa, input logic pb);
    case (code)
      hssc_pkg::SRC_ON:      srcLevel = 1'b1;
      hssc_pkg::SRC_TIMER_A: srcLevel = ta;
      hssc_pkg::SRC_TIMER_B: srcLevel = tb;
      hssc_pkg::SRC_PWM_A:   srcLevel = pa;
      hssc_pkg::SRC_PWM_B:   srcLevel = pb;
      default:               srcLevel = 1'b0;
    endcase
  endfunction : srcLevel

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] syncMeta;   // First stage, read only by second stage
  logic [7:0] syncOut;    // Second stage
  logic       ovSync;     // Synchronised overvoltage
  logic       uvSync;     // Synchronised undervoltage
  logic [3:0] faultSync;  // Synchronised per-switch faults
  logic       restartSync;// Synchronised restart request
  logic       cyclicSync; // Synchronised cyclic sensing flag

  // Two flops for every asynchronous input (pwm inputs are on-clock)
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      syncMeta <= 8'h00;
      syncOut  <= 8'h00;
    end else begin
      syncMeta <= {cyclicSense, restartMode, switchFault, supplyUv,
                   supplyOv};
      syncOut  <= syncMeta;
    end
  end

  assign ovSync      = syncOut[0];
  assign uvSync      = syncOut[1];
  assign faultSync   = syncOut[5:2];
  assign restartSync = syncOut[6];
  assign cyclicSync  = syncOut[7];

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] timerA, timerB, shutdown, srcA, srcB; // Register contents
  logic [7:0] next_timerA, next_timerB, next_shutdown;
  logic [7:0] next_srcA, next_srcB;
  logic [7:0] next_regRdata; // Read mux
  logic [7:0] faultClr;      // Field clear mask from faults

  // Writes, hardware clears; hardware clear wins over a same-cycle write
  always_comb begin
    next_timerA   = timerA;
    next_timerB   = timerB;
    next_shutdown = shutdown;
    next_srcA     = srcA;
    next_srcB     = srcB;
    if (regWrite) begin
      case (regAddr)
        hssc_pkg::ADDR_TIMER_A:
          next_timerA = regWdata & hssc_pkg::TIMER_MASK;
        hssc_pkg::ADDR_TIMER_B:
          next_timerB = regWdata & hssc_pkg::TIMER_MASK;
        hssc_pkg::ADDR_SHUTDOWN:
          next_shutdown = regWdata & hssc_pkg::SHUTDOWN_MASK;
        hssc_pkg::ADDR_SRC_SEL_A:
          next_srcA = regWdata & hssc_pkg::SRC_MASK;
        hssc_pkg::ADDR_SRC_SEL_B:
          next_srcB = regWdata & hssc_pkg::SRC_MASK;
        default: ; // Unmapped: ignored
      endcase
    end
    // Fault on a switch forces its field to the off code
    faultClr  = {1'b0, {3{faultSync[1]}}, 1'b0, {3{faultSync[0]}}};
    next_srcA = next_srcA & ~faultClr;
    faultClr  = {1'b0, {3{faultSync[3]}}, 1'b0, {3{faultSync[2]}}};
    next_srcB = next_srcB & ~faultClr;
    // Restart clears switch settings, and timers too with cyclic sense
    if (restartSync) begin
      next_srcA = hssc_pkg::RESET_VALUE;
      next_srcB = hssc_pkg::RESET_VALUE;
      if (cyclicSync) begin
        next_timerA = hssc_pkg::RESET_VALUE;
        next_timerB = hssc_pkg::RESET_VALUE;
      end
    end
    case (regAddr)
      hssc_pkg::ADDR_TIMER_A:   next_regRdata = timerA;
      hssc_pkg::ADDR_TIMER_B:   next_regRdata = timerB;
      hssc_pkg::ADDR_SHUTDOWN:  next_regRdata = shutdown;
      hssc_pkg::ADDR_SRC_SEL_A: next_regRdata = srcA;
      hssc_pkg::ADDR_SRC_SEL_B: next_regRdata = srcB;
      default:                  next_regRdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timerA   <= hssc_pkg::RESET_VALUE;
      timerB   <= hssc_pkg::RESET_VALUE;
      shutdown <= hssc_pkg::RESET_VALUE;
      srcA     <= hssc_pkg::RESET_VALUE;
      srcB     <= hssc_pkg::RESET_VALUE;
      regRdata <= 8'h00;
    end else begin
      timerA   <= next_timerA;
      timerB   <= next_timerB;
      shutdown <= next_shutdown;
      srcA     <= next_srcA;
      srcB     <= next_srcB;
      regRdata <= next_regRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tick prescaler and cyclic timers

  logic [15:0] tickCnt, next_tickCnt; // 0.1 ms prescaler
  logic        tick;                  // One-cycle tick pulse
  logic [15:0] perCnt [2];            // Tick count within period
  logic [15:0] next_perCnt [2];
  logic [1:0]  tOut, next_tOut;       // Timer outputs
  logic [7:0]  tCfg [2];              // Timer config views

  assign tick    = (tickCnt == 16'(TICK_CYCLES - 1));
  assign tCfg[0] = timerA;
  assign tCfg[1] = timerB;

  // Each timer: high for on-time from start of each period
  always_comb begin
    next_tickCnt = tick ? 16'h0000 : tickCnt + 16'h0001;
    for (int i = 0; i < 2; i++) begin
      logic [2:0]  onC;
      logic [2:0]  perC;
      logic [15:0] pLen;
      onC  = tCfg[i][hssc_pkg::ON_LSB +: 3];
      perC = tCfg[i][hssc_pkg::PER_LSB +: 3];
      pLen = perTicks(perC);
      next_perCnt[i] = perCnt[i];
      if (onC == hssc_pkg::ON_STOP_HIGH) begin
        next_perCnt[i] = 16'h0000;
        next_tOut[i]   = 1'b1;
      end else if (onTicks(onC) == 16'h0000 || pLen == 16'h0000) begin
        next_perCnt[i] = 16'h0000; // Stopped or reserved
        next_tOut[i]   = 1'b0;
      end else begin // Running as soon as on-time is nonzero
        if (tick) begin
          next_perCnt[i] = (perCnt[i] >= pLen - 16'h0001) ? 16'h0000
                           : perCnt[i] + 16'h0001;
        end
        next_tOut[i] = (perCnt[i] < onTicks(onC));
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt   <= 16'h0000;
      perCnt[0] <= 16'h0000;
      perCnt[1] <= 16'h0000;
      tOut      <= 2'b00;
    end else begin
      tickCnt   <= next_tickCnt;
      perCnt[0] <= next_perCnt[0];
      perCnt[1] <= next_perCnt[1];
      tOut      <= next_tOut;
    end
  end

  // Timer outputs feed wake logic independently of switch use
  assign timerAOut = tOut[0];
  assign timerBOut = tOut[1];

  ////////////////////////////////////////////////////////////////////////
  // Supply shutdown and switch drive

  logic       blockOn, next_blockOn; // Supply fault holds switches off
  logic       sdOv, sdUv;            // Shutdown-causing conditions
  logic [3:0] next_switchOn;
  logic [2:0] fld [4];               // Per-switch source fields

  assign fld[0] = srcA[2:0];
  assign fld[1] = srcA[6:4];
  assign fld[2] = srcB[2:0];
  assign fld[3] = srcB[6:4];
  assign sdOv   = ovSync & ~shutdown[hssc_pkg::OV_BIT];
  assign sdUv   = uvSync & ~shutdown[hssc_pkg::UV_BIT];

  // Without recovery, block stays until software rewrites a source
  always_comb begin
    next_blockOn = blockOn;
    if (sdOv || sdUv) begin
      next_blockOn = 1'b1;
    end else if (shutdown[hssc_pkg::REC_BIT]) begin
      next_blockOn = 1'b0;
    end else if (regWrite && (regAddr == hssc_pkg::ADDR_SRC_SEL_A ||
                              regAddr == hssc_pkg::ADDR_SRC_SEL_B)) begin
      next_blockOn = 1'b0;
    end
    for (int s = 0; s < 4; s++) begin
      next_switchOn[s] = ~next_blockOn &
                         srcLevel(fld[s], tOut[0], tOut[1], pwmA, pwmB);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      blockOn  <= 1'b0;
      switchOn <= 4'h0;
    end else begin
      blockOn  <= next_blockOn;
      switchOn <= next_switchOn;
    end
  end

endmodule : hssc_top

// file: verification/hssc_top_chk.sv
module hssc_top_chk #(
  parameter int TICK_CYCLES = 10 // Cycles per tick
) (
  input wire logic       core_clk,    // Clock
  input wire logic       rstn,        // Async reset, active low
  input wire logic       restartMode, // Restart level
  input wire logic       cyclicSense, // Cyclic sensing
  input wire logic       regWrite,    // Write strobe
  input wire logic [6:0] regAddr,     // Address
  input wire logic [7:0] regWdata,    // Write data
  input wire logic [7:0] regRdata,    // Read data
  input wire logic       supplyOv,    // Overvoltage
  input wire logic       supplyUv,    // Undervoltage
  input wire logic [3:0] switchFault, // Per-switch fault
  input wire logic       pwmA,        // Pwm_a level
  input wire logic       pwmB,        // Pwm_b level
  input wire logic [3:0] switchOn,    // Switch drive
  input wire logic       timerAOut,   // Timer_a level
  input wire logic       timerBOut    // Timer_b level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the two shutdown disable bits
  logic [1:0] sdBits;      // Ov, uv disable
  logic [1:0] next_sdBits; // Next value
  // Only a write to the shutdown register moves the shadow
  always_comb begin
    next_sdBits = sdBits;
    if (regWrite && regAddr == hssc_pkg::ADDR_SHUTDOWN) begin
      next_sdBits = regWdata[6:5];
    end
  end
  // Register the shadow
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sdBits <= 2'h0;
    end else begin
      sdBits <= next_sdBits;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  rsvd_read_zero_a: assert property (
    regRdata[7] == 1'b0 && regRdata[3] == 1'b0)
    else $error("reserved read bit set");
  src_off_a: assert property (
    regWrite && regAddr == hssc_pkg::ADDR_SRC_SEL_A &&
    regWdata[2:0] == 3'h0 |-> ##2 !switchOn[0])
    else $error("switch 1 on");
  src_rsvd_a: assert property (
    regWrite && regAddr == hssc_pkg::ADDR_SRC_SEL_B &&
    regWdata[6:5] == 2'h3 |-> ##2 !switchOn[3])
    else $error("switch 4 on");
  timer_low_a: assert property (
    regWrite && regAddr == hssc_pkg::ADDR_TIMER_B &&
    regWdata[6:4] == 3'h0 |-> ##3 !timerBOut)
    else $error("timer b high");
  timer_high_a: assert property (
    regWrite && regAddr == hssc_pkg::ADDR_TIMER_B &&
    regWdata[6:4] == 3'h6 |-> ##3 timerBOut)
    else $error("timer b low");
  ov_shutdown_a: assert property (
    (supplyOv && !sdBits[1])[*5] |-> switchOn == 4'h0)
    else $error("switches on in overvoltage");
  uv_shutdown_a: assert property (
    (supplyUv && !sdBits[0])[*5] |-> switchOn == 4'h0)
    else $error("switches on in undervoltage");
  // Switch 3 is the one the bench faults; sync plus clear takes 4 cycles
  fault_clear_a: assert property (
    switchFault[2][*5] |-> !switchOn[2])
    else $error("faulted switch on");
  restart_clear_a: assert property (
    (restartMode && cyclicSense)[*6] |-> !timerBOut && switchOn == 4'h0)
    else $error("restart left outputs");
  ////////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  cover property ($rose(timerBOut));
  cover property ((supplyUv && sdBits[0])[*5]);
  cover property (switchFault[2][*5]);
endmodule : hssc_top_chk

bind hssc_top hssc_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_hssc_top_chk (.*);

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, rstn, restartMode, cyclicSense, regWrite; // Controls
  logic       supplyOv, supplyUv, pwmA, pwmB, timerAOut, timerBOut; // Levels
  logic [6:0] regAddr;                // Address
  logic [7:0] regWdata, regRdata;     // Data
  logic [3:0] switchFault, switchOn;  // Per-switch
  int         fails, comparisons, cyc; // Counters
  logic [6:0] adr [5] = '{7'h0C, 7'h0D, 7'h10, 7'h14, 7'h15}; // Mapped
  logic [7:0] msk [5] = '{8'h77, 8'h77, 8'h70, 8'h77, 8'h77}; // Writable
  int         onT [5] = '{1, 3, 10, 100, 200}; // On ticks
  logic       e;                      // Expected drive
  // Short tick keeps long periods affordable
  hssc_top #(.TICK_CYCLES(10)) i_hssc_top (.core_clk(core_clk), .rstn(rstn),
    .restartMode(restartMode), .cyclicSense(cyclicSense), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .supplyOv(supplyOv), .supplyUv(supplyUv), .switchFault(switchFault),
    .pwmA(pwmA), .pwmB(pwmB), .switchOn(switchOn), .timerAOut(timerAOut),
    .timerBOut(timerBOut));
  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard, well above the timer sweep
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Drives settle one step after the edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // Write, then let the drive update land
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    step(1);
    regWrite = 1'b0;
    step(2);
  endtask : wr
  // Read data is registered behind the address
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    regAddr = a;
    step(2);
    chk(regRdata, x);
  endtask : rd
  // Skip the pulse in flight, then time one full pulse and period
  task automatic tmeas(input int hi, input int per);
    int h;
    int n;
    n = 0;
    while (timerBOut === 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    while (timerBOut !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    h = 0;
    while (timerBOut === 1'b1 && h < 20000) begin
      step(1);
      h++;
    end
    n = h;
    while (timerBOut !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    chk(h[15:0], hi[15:0]);
    chk(n[15:0], per[15:0]);
  endtask : tmeas
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, restartMode, cyclicSense, regWrite, supplyOv, supplyUv} = 6'h00;
    {pwmA, pwmB, regAddr, regWdata, switchFault} = 21'h0;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    step(1);
    // Reset values, then reserved bits
    for (int i = 0; i < 5; i++) rd(adr[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
    end
    chk(switchOn, 4'h0);
    wr(7'h11, 8'hFF);
    rd(7'h11, 8'h00);
    wr(adr[2], 8'h00);
    // Every source code on every switch, timers and pwm swapped
    for (int p = 0; p < 2; p++) begin
      pwmA = !p;
      pwmB = p;
      wr(adr[0], p ? 8'h00 : 8'h60);
      wr(adr[1], p ? 8'h60 : 8'h00);
      chk(timerAOut, 16'(!p));
      chk(timerBOut, 16'(p));
      for (int s = 0; s < 4; s++) begin
        for (int c = 0; c < 8; c++) begin
          wr(adr[3 + s / 2], 8'(c << (s % 2 * 4)));
          e = c == 1 || (p ? c == 3 || c == 5 : c == 2 || c == 4);
          chk(switchOn, 16'(e) << s);
        end
      end
    end
    // Per-switch fault clears only its own field
    wr(adr[3], 8'h11);
    wr(adr[4], 8'h11);
    switchFault = 4'h4;
    step(5);
    switchFault = 4'h0;
    rd(adr[4], 8'h10);
    chk(switchOn, 4'hB);
    wr(adr[4], 8'h11);
    // Shutdown without recovery holds off until rewritten
    supplyOv = 1'b1;
    step(6);
    chk(switchOn, 4'h0);
    supplyOv = 1'b0;
    step(6);
    chk(switchOn, 4'h0);
    rd(adr[3], 8'h11);
    wr(adr[3], 8'h11);
    wr(adr[4], 8'h11);
    chk(switchOn, 4'hF);
    // Overvoltage ignored, undervoltage with recovery
    wr(adr[2], 8'h50);
    supplyOv = 1'b1;
    step(6);
    chk(switchOn, 4'hF);
    supplyOv = 1'b0;
    supplyUv = 1'b1;
    step(6);
    chk(switchOn, 4'h0);
    supplyUv = 1'b0;
    step(6);
    chk(switchOn, 4'hF);
    wr(adr[2], 8'h30);
    supplyUv = 1'b1;
    step(6);
    chk(switchOn, 4'hF);
    supplyUv = 1'b0;
    // Assign first, then each running on-time starts the timer
    wr(adr[4], 8'h00);
    wr(adr[3], 8'h03);
    for (int o = 1; o < 6; o++) begin
      wr(adr[1], 8'h00);
      wr(adr[1], 8'((o << 4) | (o < 4 ? 0 : 2)));
      tmeas(onT[o - 1] * 10, o < 4 ? 1000 : 5000);
    end
    // Restart with cyclic sensing wipes timer and sources
    cyclicSense = 1'b1;
    restartMode = 1'b1;
    step(6);
    restartMode = 1'b0;
    step(2);
    rd(adr[1], 8'h00);
    rd(adr[3], 8'h00);
    chk(timerBOut, 1'b0);
    report_and_stop();
  end
endmodule : testbench
